//--- cmd_reset_asserts.sv
// checker for the command decoder ports
// assumes bind to cmd_reset_ctrl, one clock domain
`timescale 1ns/1ns
`default_nettype none
module cmd_reset_asserts #(parameter int unsigned num_counters = 5) (
	// watched ports
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic pointer_load,
	input wire logic cmd_sel,
	input wire logic write_prefetch_en,
	input wire logic [num_counters-1:0] counter_armed,
	input wire logic [15:0] global_mode,
	input wire logic [num_counters*16-1:0] counter_mode,
	input wire logic [num_counters*16-1:0] load_value,
	input wire logic [num_counters*16-1:0] hold_value,
	input wire logic [7:0] data_pointer,
	input wire logic master_reset_pulse,
	input wire logic cmd_strobe,
	input wire logic [7:0] cmd_byte
);
	// cycles since a command-port write was last seen on the raw pins
	logic [3:0] gap_q;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n) gap_q <= 4'hf;
		else if (!chip_sel_n && !write_n && cmd_sel) gap_q <= 4'h0;
		else if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_soft_reset;
		cmd_strobe && cmd_byte == 8'hff;
	endsequence
	AST_PF_ON: assert property (cmd_strobe && cmd_byte == 8'hf8 |-> write_prefetch_en)
		else $error("prefetch off after enable");
	AST_SOFT_RST: assert property (s_soft_reset |-> master_reset_pulse)
		else $error("no reset pulse for ff");
	AST_CLEAR: assert property (master_reset_pulse |=> !counter_armed && !global_mode && !load_value && !hold_value)
		else $error("registers not cleared");
	AST_MODE: assert property (master_reset_pulse |=> counter_mode == {num_counters{16'h0800}})
		else $error("counter mode not 0800");
	AST_PTR: assert property (master_reset_pulse && !pointer_load |=> $stable(data_pointer))
		else $error("pointer changed by reset");
	AST_PF_HOLD: assert property ($rose(write_prefetch_en) |-> (cmd_strobe && cmd_byte == 8'hf8) || $past(master_reset_pulse))
		else $error("prefetch on without command");
	AST_CMD_PORT: assert property (cmd_strobe |-> gap_q < 4'hc)
		else $error("command without command-port write");
endmodule // cmd_reset_asserts
bind cmd_reset_ctrl cmd_reset_asserts #(.num_counters(num_counters)) asserts_inst (.sys_clk(sys_clk),
	.rst_n(rst_n), .chip_sel_n(chip_sel_n), .write_n(write_n), .pointer_load(pointer_load),
	.cmd_sel(cmd_sel), .write_prefetch_en(write_prefetch_en),
	.counter_armed(counter_armed), .global_mode(global_mode), .counter_mode(counter_mode),
	.load_value(load_value), .hold_value(hold_value), .data_pointer(data_pointer),
	.master_reset_pulse(master_reset_pulse), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte));
`default_nettype wire

//--- cmd_reset_ctrl.sv
// command decoder for write prefetch control and software master reset
// assumes host pins asynchronous to sys_clk; data register writes come from elsewhere
`timescale 1ns/1ns
`default_nettype none
module cmd_reset_ctrl #(
	parameter int unsigned num_counters = cmd_reset_pkg::num_counters
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// host command port pins
	input wire logic chip_sel_n,
	input wire logic write_n,
	input wire logic cmd_sel,
	input wire logic [7:0] host_data,
	// data pointer load from the pointer logic
	input wire logic pointer_load,
	input wire logic [7:0] pointer_value,
	// datapath write ports from the data register path
	input wire logic global_mode_wr,
	input wire logic [15:0] global_mode_wdata,
	// state presented to the counter datapath
	output logic write_prefetch_en,
	output logic [num_counters-1:0] counter_armed,
	output logic [15:0] global_mode,
	output logic [num_counters*16-1:0] counter_mode,
	output logic [num_counters*16-1:0] load_value,
	output logic [num_counters*16-1:0] hold_value,
	output logic [7:0] data_pointer,
	output logic master_reset_pulse,
	output logic cmd_strobe,
	output logic [7:0] cmd_byte
);
	// which port the host write seen in the last cycle was aimed at
	typedef enum logic [2:0] {
		port_idle = 3'b001,
		cmd_write = 3'b010,
		data_write = 3'b100
	} port_state_type;

	logic [10:0] pins_sync;
	logic host_cs;
	logic host_wr;
	logic host_cmd;
	logic cmd_fire;
	logic [7:0] cmd_latched;
	logic [7:0] cmd_q;
	logic cmd_strobe_q;
	logic soft_reset_q;
	logic prefetch_en_q;
	logic [num_counters-1:0] armed_q;
	logic [15:0] global_mode_q;
	// one word per counter, flattened only at the ports
	logic [15:0] counter_mode_q [num_counters];
	logic [15:0] load_q [num_counters];
	logic [15:0] hold_q [num_counters];
	logic [7:0] pointer_q;
	port_state_type port_state_q;

	// counter 0 lands in the low word of the flat port
	function automatic logic [num_counters*16-1:0] flatten(input logic [15:0] words [num_counters]);
		logic [num_counters*16-1:0] flat;
		flat = '0;
		for (int i = 0; i < num_counters; i++) begin
			flat[i*16 +: 16] = words[i];
		end
		return flat;
	endfunction

	// an opcode acts only in the cycle its write completes
	function automatic logic cmd_hit(input logic fire, input logic [7:0] held, input logic [7:0] opcode);
		return fire && (held == opcode);
	endfunction

	pin_sync #(
		.width(11)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pin({~chip_sel_n, ~write_n, cmd_sel, host_data}),
		.level(pins_sync)
	);

	assign host_cs = pins_sync[10];
	assign host_wr = pins_sync[9];
	assign host_cmd = pins_sync[8];
	assign cmd_latched = pins_sync[7:0];

	// the port select only has to be valid by the end of the write, so the
	// decision is taken from the last cycle before the release
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_state_q <= port_idle;
		end else begin
			case (port_state_q)
				port_idle: begin
					if (host_cs && host_wr && host_cmd) begin
						port_state_q <= cmd_write;
					end else if (host_cs && host_wr) begin
						port_state_q <= data_write;
					end
				end
				data_write: begin
					if (!(host_cs && host_wr)) begin
						port_state_q <= port_idle;
					end else if (host_cmd) begin
						port_state_q <= cmd_write;
					end
				end
				cmd_write: begin
					if (!(host_cs && host_wr)) begin
						port_state_q <= port_idle;
					end else if (!host_cmd) begin
						port_state_q <= data_write;
					end
				end
				default: begin
					port_state_q <= port_idle;
				end
			endcase
		end
	end

	// a command executes on the release of write, when the byte has long settled
	assign cmd_fire = (port_state_q == cmd_write) && !(host_cs && host_wr);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_strobe_q <= 1'b0;
		end else begin
			cmd_strobe_q <= cmd_fire;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= 8'h00;
		end else if (host_cs && host_wr && host_cmd) begin
			cmd_q <= cmd_latched;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_q <= 1'b0;
		end else begin
			soft_reset_q <= cmd_hit(cmd_fire, cmd_q, cmd_reset_pkg::op_master_reset);
		end
	end

	// reset command re-enables prefetch just as power-on does
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prefetch_en_q <= 1'b1;
		end else if (soft_reset_q) begin
			prefetch_en_q <= 1'b1;
		end else if (cmd_hit(cmd_fire, cmd_q, cmd_reset_pkg::op_prefetch_on)) begin
			prefetch_en_q <= 1'b1;
		end else if (cmd_hit(cmd_fire, cmd_q, cmd_reset_pkg::op_prefetch_off)) begin
			prefetch_en_q <= 1'b0;
		end
	end

	// only the reset path is modelled here; arming belongs to the counter datapath
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= '0;
		end else if (soft_reset_q) begin
			armed_q <= '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			global_mode_q <= cmd_reset_pkg::global_mode_reset;
		end else if (soft_reset_q) begin
			global_mode_q <= cmd_reset_pkg::global_mode_reset;
		end else if (global_mode_wr) begin
			global_mode_q <= global_mode_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < num_counters; i++) begin
				counter_mode_q[i] <= cmd_reset_pkg::counter_mode_reset;
			end
		end else if (soft_reset_q) begin
			for (int i = 0; i < num_counters; i++) begin
				counter_mode_q[i] <= cmd_reset_pkg::counter_mode_reset;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < num_counters; i++) begin
				load_q[i] <= cmd_reset_pkg::load_reset;
			end
		end else if (soft_reset_q) begin
			for (int i = 0; i < num_counters; i++) begin
				load_q[i] <= cmd_reset_pkg::load_reset;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < num_counters; i++) begin
				hold_q[i] <= cmd_reset_pkg::hold_reset;
			end
		end else if (soft_reset_q) begin
			for (int i = 0; i < num_counters; i++) begin
				hold_q[i] <= cmd_reset_pkg::hold_reset;
			end
		end
	end

	// the pointer ignores soft reset; an async clear is unavoidable for defined state,
	// so its power-on value is arbitrary and software must program it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_q <= cmd_reset_pkg::pointer_reset;
		end else if (pointer_load) begin
			pointer_q <= pointer_value;
		end
	end

	assign write_prefetch_en = prefetch_en_q;
	assign counter_armed = armed_q;
	assign global_mode = global_mode_q;
	assign counter_mode = flatten(counter_mode_q);
	assign load_value = flatten(load_q);
	assign hold_value = flatten(hold_q);
	assign data_pointer = pointer_q;
	assign master_reset_pulse = soft_reset_q;
	assign cmd_strobe = cmd_strobe_q;
	assign cmd_byte = cmd_q;
endmodule // cmd_reset_ctrl
`default_nettype wire

//--- cmd_reset_pkg.sv
// constants for the command decoder: opcodes, reset values, widths
// assumes nothing beyond a SystemVerilog compiler
package cmd_reset_pkg;
	localparam int unsigned num_counters = 5;
	localparam int unsigned reg_width = 16;
	localparam logic [7:0] op_master_reset = 8'hff;
	localparam logic [7:0] op_prefetch_on = 8'hf8;
	localparam logic [7:0] op_prefetch_off = 8'hf9;
	localparam logic [7:0] op_load_all = 8'h5f;
	localparam logic [15:0] global_mode_reset = 16'h0000;
	localparam logic [15:0] counter_mode_reset = 16'h0800;
	localparam logic [15:0] load_reset = 16'h0000;
	localparam logic [15:0] hold_reset = 16'h0000;
	localparam logic [7:0] pointer_reset = 8'h00;
	localparam int unsigned sync_stages = 3;
endpackage

//--- host_model.sv
// host processor model writing the command or data port
// assumes sys_clk only paces it; pins are async to the design
`timescale 1ns/1ns
`default_nettype none
module host_model (
	// clock
	input wire logic sys_clk,
	// port pins
	output logic chip_sel_n,
	output logic write_n,
	output logic cmd_sel,
	output logic [7:0] host_data
);
	initial begin
		{chip_sel_n, write_n, cmd_sel, host_data} = {3'h6, 8'h00};
	end
	// long low and high phases so the synchroniser filter sees every write
	task automatic put(input logic port, input logic [7:0] b);
		@(posedge sys_clk);
		{chip_sel_n, write_n, cmd_sel, host_data} <= {2'h0, port, b};
		repeat (6) @(posedge sys_clk);
		{chip_sel_n, write_n, host_data} <= {2'h3, ~b};
		repeat (10) @(posedge sys_clk);
	endtask
endmodule // host_model
`default_nettype wire

//--- pin_sync.sv
// three-stage synchroniser for a pin; change accepted once stages two and three agree
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int unsigned width = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// pin side
	input wire logic [width-1:0] pin,
	// synchronised side
	output logic [width-1:0] level
);
	logic [width-1:0] s1_q;
	logic [width-1:0] s2_q;
	logic [width-1:0] s3_q;
	logic [width-1:0] level_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// bitwise agreement filters a single-cycle metastable resolve
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= '0;
		end else begin
			level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
		end
	end

	assign level = level_q;
endmodule // pin_sync
`default_nettype wire

//--- test_timer_reset_prefetch_cmds.sv
// testbench for the command decoder
// assumes host_model and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
module test_timer_reset_prefetch_cmds;
	logic sys_clk = 1'b0, rst_n = 1'b0, pointer_load = 1'b0, global_mode_wr = 1'b0;
	logic chip_sel_n, write_n, cmd_sel, write_prefetch_en, master_reset_pulse, cmd_strobe;
	logic [7:0] host_data, data_pointer, cmd_byte, pointer_value = 8'h00;
	logic [15:0] global_mode, global_mode_wdata = 16'h0000;
	logic [4:0] counter_armed;
	logic [79:0] counter_mode, load_value, hold_value;
	int n_fail = 0, tests_run = 0, cycles = 0, n_strobe = 0, n_reset = 0;
	always #20 sys_clk = ~sys_clk;
	cmd_reset_ctrl cmd_reset_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .chip_sel_n(chip_sel_n),
		.write_n(write_n), .cmd_sel(cmd_sel), .host_data(host_data), .pointer_load(pointer_load),
		.pointer_value(pointer_value), .global_mode_wr(global_mode_wr), .global_mode_wdata(global_mode_wdata),
		.write_prefetch_en(write_prefetch_en), .counter_armed(counter_armed), .global_mode(global_mode),
		.counter_mode(counter_mode), .load_value(load_value), .hold_value(hold_value),
		.data_pointer(data_pointer), .master_reset_pulse(master_reset_pulse), .cmd_strobe(cmd_strobe),
		.cmd_byte(cmd_byte));
	host_model host_model_inst (.sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .write_n(write_n),
		.cmd_sel(cmd_sel), .host_data(host_data));
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		// pulses last one cycle, so they are counted here rather than compared late
		if (cmd_strobe) n_strobe++;
		if (master_reset_pulse) n_reset++;
		if (cycles == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		chk(counter_mode, {5{16'h0800}});
		@(posedge sys_clk);
		{pointer_load, pointer_value, global_mode_wr, global_mode_wdata} <= {9'h15a, 17'h11234};
		@(posedge sys_clk);
		{pointer_load, global_mode_wr} <= 2'h0;
		host_model_inst.put(1'b1, 8'hf9);
		chk(global_mode, 16'h1234);
		host_model_inst.put(1'b0, 8'hf8);
		chk(write_prefetch_en, 1'b0);
		chk(n_strobe, 1);
		host_model_inst.put(1'b1, 8'hf8);
		chk(write_prefetch_en, 1'b1);
		host_model_inst.put(1'b1, 8'hf9);
		chk(write_prefetch_en, 1'b0);
		host_model_inst.put(1'b1, 8'hff);
		chk(write_prefetch_en, 1'b1);
		chk(n_reset, 1);
		chk(cmd_byte, 8'hff);
		chk({global_mode, counter_armed}, 80'h0);
		chk(load_value | hold_value, 80'h0);
		chk(counter_mode, {5{16'h0800}});
		chk(data_pointer, 8'h5a);
		host_model_inst.put(1'b1, 8'h5f);
		chk(cmd_byte, 8'h5f);
		chk(n_strobe, 5);
		chk(n_reset, 1);
		@(posedge sys_clk);
		{pointer_load, pointer_value} <= 9'h13c;
		@(posedge sys_clk);
		{pointer_load, global_mode_wr, global_mode_wdata} <= {2'h1, 16'h4321};
		@(posedge sys_clk);
		global_mode_wr <= 1'b0;
		@(posedge sys_clk);
		chk(data_pointer, 8'h3c);
		chk(global_mode, 16'h4321);
		end_of_test();
	end
endmodule // test_timer_reset_prefetch_cmds
`default_nettype wire
